// ---- tsic_top.sv ----
`timescale 1ns/1ps
module tsic_top #(
	parameter int WAKE_LONG_CYCLES = tsic_pkg::WAKE_LONG_DEFAULT
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic por_cause_i,
	input wire logic wdt_cause_i,
	input wire logic [tsic_pkg::ADDR_W-1:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [tsic_pkg::DATA_W-1:0] io_wdata_i,
	output logic [tsic_pkg::DATA_W-1:0] io_rdata_o,
	input wire logic instr_last_i,
	input wire logic halt_instr_i,
	input wire logic irq_disable_instruction_i,
	input wire logic irq_enable_instruction_i,
	input wire logic irq_return_instruction_i,
	input wire logic [tsic_pkg::PC_W-1:0] pc_i,
	input wire logic carry_flag_i,
	input wire logic zero_flag_i,
	input wire logic [tsic_pkg::PC_W+1:0] stack_top_i,
	input wire logic usb_dp_i,
	input wire logic usb_dm_i,
	input wire logic bus_activity_i,
	input wire logic [2:0] ep_packet_done_i,
	output logic cpu_run_o,
	output logic ack_busy_o,
	output logic irq_call_o,
	output logic [15:0] irq_vector_o,
	output logic [tsic_pkg::PC_W+1:0] stack_push_data_o,
	output logic restore_valid_o,
	output logic [tsic_pkg::PC_W-1:0] restore_pc_o,
	output logic restore_carry_flag_o,
	output logic restore_zero_flag_o,
	output logic [tsic_pkg::TIMER_W-1:0] timer_count_o
);
	import tsic_pkg::*;

	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam int WAKE_W = $clog2(WAKE_LONG_CYCLES + WAKE_SHORT_CYCLES + 1);
	localparam int SE0_W = $clog2(SE0_CYCLES + 2);

	// lowest index wins, which is also the lowest vector number
	function automatic logic [2:0] pick_lowest(input logic [NUM_SRC-1:0] req);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	function automatic logic [15:0] vector_of(input logic [2:0] idx);
		return RESET_VECTOR + VECTOR_STEP * (16'(idx) + 16'h0001);
	endfunction

	logic [PRE_W-1:0] pre_reg;
	logic [TIMER_W-1:0] count_reg;
	logic [3:0] hold_reg;
	logic [2:0] gen_reg;
	logic [2:0] ep_en_reg;
	logic [NUM_SRC-1:0] latch_reg;
	logic run_reg;
	logic step_reg;
	logic gie_reg;
	logic suspend_reg;
	logic por_reg;
	logic busrst_reg;
	logic wdt_reg;
	logic pend_reg;
	logic [WAKE_W-1:0] wake_reg;
	logic [SE0_W-1:0] se0_reg;
	tsic_ack_state_t state_reg;
	logic [2:0] idx_reg;
	logic [15:0] vector_reg;
	logic [PC_W+1:0] push_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic restore_valid_reg;
	logic [PC_W+1:0] restore_reg;

	wire tick = (pre_reg == PRE_W'(TICK_CYCLES - 1));
	wire fast_ev = tick && (count_reg[FAST_CARRY_BIT:0] == {(FAST_CARRY_BIT + 1){1'b1}});
	wire slow_ev = tick && (count_reg[SLOW_CARRY_BIT:0] == {(SLOW_CARRY_BIT + 1){1'b1}});
	wire se0 = !usb_dp_i && !usb_dm_i;
	wire busrst_ev = se0 && (se0_reg == SE0_W'(SE0_CYCLES));
	wire [NUM_SRC-1:0] event_vec = {ep_packet_done_i, slow_ev, fast_ev, busrst_ev};
	wire [NUM_SRC-1:0] enable_vec = {ep_en_reg, gen_reg};
	wire [NUM_SRC-1:0] active_vec = latch_reg & enable_vec;
	wire any_req = |active_vec;
	wire wake_req = bus_activity_i || any_req;
	wire awake = !suspend_reg && (wake_reg == '0);
	wire running = run_reg && awake;

	wire wr_status = io_wr_i && (io_addr_i == ADDR_STATUS);
	wire wr_gen = io_wr_i && (io_addr_i == ADDR_GLOBAL_EN);
	wire wr_ep = io_wr_i && (io_addr_i == ADDR_EP_EN);
	wire rd_low = io_rd_i && (io_addr_i == ADDR_TMR_LOW);

	// sampling only at the final cycle keeps instructions atomic
	wire take = (state_reg == ACK_IDLE) && instr_last_i && gie_reg && any_req && running;
	wire halt_now = instr_last_i && running && halt_instr_i;
	wire step_now = instr_last_i && running && step_reg;
	wire ret_now = instr_last_i && running && irq_return_instruction_i;
	wire [NUM_SRC-1:0] clr_mask = (state_reg == ACK_CLEAR) ? NUM_SRC'(1) << idx_reg : '0;

	wire [7:0] reset_status = (wdt_cause_i && !por_cause_i) ? STATUS_WDT_VALUE : STATUS_POR_VALUE;
	wire [7:0] status_view = {pend_reg, wdt_reg, busrst_reg, por_reg, suspend_reg, gie_reg,
		step_reg, run_reg};

	wire [TIMER_W-1:0] count_next = tick ? count_reg + TIMER_W'(1) : count_reg;
	wire [PRE_W-1:0] pre_next = tick ? '0 : pre_reg + PRE_W'(1);
	wire [SE0_W-1:0] se0_next = !se0 ? '0 : (se0_reg > SE0_W'(SE0_CYCLES)) ? se0_reg :
		se0_reg + SE0_W'(1);
	wire [NUM_SRC-1:0] latch_next = (latch_reg & ~clr_mask) | event_vec; // set wins

	// a write of zero to run halts, so firmware must keep it at one
	wire run_next = (halt_now || step_now) ? 1'b0 : wr_status ? io_wdata_i[ST_RUN] : run_reg;
	wire step_next = wr_status ? io_wdata_i[ST_STEP] : step_reg;
	wire gie_next = (state_reg == ACK_MASK) ? 1'b0 :
		(instr_last_i && running && irq_disable_instruction_i) ? 1'b0 :
		(instr_last_i && running && (irq_enable_instruction_i || irq_return_instruction_i)) ? 1'b1 :
		gie_reg; // mask bit write ignored
	wire suspend_next = suspend_reg ? !wake_req :
		(wr_status && io_wdata_i[ST_SUSPEND] && !wake_req);
	wire [WAKE_W-1:0] wake_load = por_reg ? WAKE_W'(WAKE_LONG_CYCLES) : WAKE_W'(WAKE_SHORT_CYCLES);
	wire [WAKE_W-1:0] wake_next = (suspend_reg && wake_req) ? wake_load :
		(wake_reg != '0) ? wake_reg - WAKE_W'(1) : wake_reg;
	wire por_next = wr_status ? io_wdata_i[ST_POR] : por_reg;
	wire busrst_next = busrst_ev || (wr_status ? io_wdata_i[ST_BUSRST] : busrst_reg);
	wire wdt_next = wr_status ? io_wdata_i[ST_WDT] : wdt_reg;
	wire pend_next = (|(event_vec & enable_vec)) || (pend_reg && (state_reg != ACK_CLEAR));

	wire [DATA_W-1:0] rd_mux = (io_addr_i == ADDR_TMR_LOW) ? count_reg[7:0] :
		(io_addr_i == ADDR_TMR_HIGH) ? {4'h0, hold_reg} :
		(io_addr_i == ADDR_STATUS) ? status_view :
		(io_addr_i == ADDR_GLOBAL_EN) ? {5'h00, gen_reg} :
		(io_addr_i == ADDR_EP_EN) ? {5'h00, ep_en_reg} : 8'h00;

	tsic_ack_state_t state_next;
	always_comb begin
		case (state_reg)
			ACK_IDLE: state_next = take ? ACK_MASK : ACK_IDLE;
			ACK_MASK: state_next = ACK_CLEAR;
			ACK_CLEAR: state_next = ACK_CALL;
			ACK_CALL: state_next = ACK_IDLE;
			default: state_next = ACK_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pre_reg <= '0;
			count_reg <= '0;
			hold_reg <= 4'h0;
			se0_reg <= '0;
			latch_reg <= '0;
		end else begin
			pre_reg <= pre_next;
			count_reg <= count_next;
			hold_reg <= rd_low ? count_reg[11:8] : hold_reg;
			se0_reg <= se0_next;
			latch_reg <= latch_next;
		end
	end

	// bus reset is only an interrupt, so nothing here clears on it
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			gen_reg <= GLOBAL_EN_RESET;
			ep_en_reg <= EP_EN_RESET;
			run_reg <= reset_status[ST_RUN];
			step_reg <= reset_status[ST_STEP];
			gie_reg <= reset_status[ST_MASK];
			suspend_reg <= reset_status[ST_SUSPEND];
			por_reg <= reset_status[ST_POR];
			busrst_reg <= reset_status[ST_BUSRST];
			wdt_reg <= reset_status[ST_WDT];
			pend_reg <= reset_status[ST_PEND];
			wake_reg <= '0;
		end else begin
			gen_reg <= wr_gen ? io_wdata_i[2:0] : gen_reg;
			ep_en_reg <= wr_ep ? io_wdata_i[2:0] : ep_en_reg;
			run_reg <= run_next;
			step_reg <= step_next;
			gie_reg <= gie_next;
			suspend_reg <= suspend_next;
			por_reg <= por_next;
			busrst_reg <= busrst_next;
			wdt_reg <= wdt_next;
			pend_reg <= pend_next;
			wake_reg <= wake_next;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= ACK_IDLE;
			idx_reg <= 3'h0;
			vector_reg <= RESET_VECTOR;
			push_reg <= '0;
			rdata_reg <= 8'h00;
			restore_valid_reg <= 1'b0;
			restore_reg <= '0;
		end else begin
			state_reg <= state_next;
			idx_reg <= take ? pick_lowest(active_vec) : idx_reg;
			vector_reg <= take ? vector_of(pick_lowest(active_vec)) : vector_reg;
			push_reg <= take ? {carry_flag_i, zero_flag_i, pc_i} : push_reg;
			rdata_reg <= io_rd_i ? rd_mux : rdata_reg;
			restore_valid_reg <= ret_now;
			restore_reg <= ret_now ? stack_top_i : restore_reg;
		end
	end

	assign io_rdata_o = rdata_reg;
	assign cpu_run_o = running && (state_reg == ACK_IDLE);
	assign ack_busy_o = (state_reg != ACK_IDLE);
	assign irq_call_o = (state_reg == ACK_CALL);
	assign irq_vector_o = vector_reg;
	assign stack_push_data_o = push_reg;
	assign restore_valid_o = restore_valid_reg;
	assign restore_pc_o = restore_reg[PC_W-1:0];
	assign restore_carry_flag_o = restore_reg[PC_W+1];
	assign restore_zero_flag_o = restore_reg[PC_W];
	assign timer_count_o = count_reg;

	a_low_read_latch: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		rd_low |=> hold_reg == $past(count_reg[11:8]))
		else $error("high nibble not latched on low read");
	a_high_read_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(io_rd_i && io_addr_i == ADDR_TMR_HIGH && !rd_low) |=> io_rdata_o == {4'h0, $past(hold_reg)})
		else $error("high read not from held nibble");
	a_fast_carry_req: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		fast_ev |=> latch_reg[1])
		else $error("fast timer request missing");
	a_halt_clears_run: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		halt_now |=> !run_reg && !cpu_run_o)
		else $error("halt did not stop run");
	a_mask_read_view: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(io_rd_i && io_addr_i == ADDR_STATUS) |=> io_rdata_o[ST_MASK] == $past(gie_reg))
		else $error("mask bit not enable state");
	a_suspend_refused: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(!suspend_reg && wr_status && wake_req) |=> !suspend_reg)
		else $error("suspend taken despite wake");
	a_bus_reset_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		busrst_ev |=> busrst_reg && latch_reg[0] && $stable(run_reg))
		else $error("bus reset flag not set");
	a_ack_sequence: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		take |=> state_reg == ACK_MASK ##1 (!gie_reg && state_reg == ACK_CLEAR)
		##1 (irq_call_o && (!latch_reg[idx_reg] || $past(event_vec[idx_reg]))))
		else $error("acknowledge order broken");
	a_enables_reset: assert property (@(posedge clk_sys_i)
		reset_i |=> gen_reg == 3'h0 && ep_en_reg == 3'h0)
		else $error("enables not cleared by reset");
	a_return_enables: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(ret_now && state_reg != ACK_MASK) |=> gie_reg && restore_valid_o)
		else $error("return did not re-enable");
	a_pend_cleared: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(state_reg == ACK_CLEAR && !(|(event_vec & enable_vec))) |=> !pend_reg)
		else $error("pending not cleared by acknowledge");
	a_lowest_first: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		(take && active_vec[0]) |=> irq_vector_o == 16'h0002)
		else $error("priority order broken");
endmodule // tsic_top

// ---- tsic_pkg.sv ----
// Operation
// - twelve-bit free-running readable timer count
// - periodic requests every 128 us and 1.024 ms
// - low byte read latches high nibble
// - halt clears run until power or watchdog
// - single step runs one instruction, clears run
// - mask bit shows enable state, writes ignored
// - suspend bit sleeps until interrupt or activity
// - suspend write ignored when wake already pending
// - power-on flag selects wake delay length
// - long single-ended zero sets bus-reset flag, request
// - watchdog reset sets watchdog flag
// - pending flag set on request, cleared by acknowledge
// - reset loads 0x11 or 0x41 into status
// - enable bits gate each interrupt source
// - any reset clears both enable registers
// - requests sampled in last instruction cycle only
// - acknowledge: mask, clear latch, call vector
// - call pushes pc and flags, return restores
// - nesting allowed once firmware re-enables
// - vectors two bytes apart from 0x0002
// - endpoint request after packet sent on bus
package tsic_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PC_W = 16;
	localparam logic [7:0] ADDR_GLOBAL_EN = 8'h20;
	localparam logic [7:0] ADDR_EP_EN = 8'h21;
	localparam logic [7:0] ADDR_TMR_LOW = 8'h24;
	localparam logic [7:0] ADDR_TMR_HIGH = 8'h25;
	localparam logic [7:0] ADDR_STATUS = 8'hFF;
	localparam int ST_RUN = 0;
	localparam int ST_STEP = 1;
	localparam int ST_MASK = 2;
	localparam int ST_SUSPEND = 3;
	localparam int ST_POR = 4;
	localparam int ST_BUSRST = 5;
	localparam int ST_WDT = 6;
	localparam int ST_PEND = 7;
	localparam logic [7:0] STATUS_POR_VALUE = 8'h11;
	localparam logic [7:0] STATUS_WDT_VALUE = 8'h41;
	localparam logic [2:0] GLOBAL_EN_RESET = 3'h0;
	localparam logic [2:0] EP_EN_RESET = 3'h0;
	localparam int NUM_SRC = 6;
	localparam int TIMER_W = 12;
	localparam int FAST_CARRY_BIT = 6;
	localparam int SLOW_CARRY_BIT = 9;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SE0_NS = 8000;
	localparam int SE0_CYCLES = SE0_NS / CLK_PERIOD_NS;
	localparam int WAKE_SHORT_US = 128;
	localparam int WAKE_SHORT_CYCLES = (WAKE_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_LONG_MS = 96;
	localparam int WAKE_LONG_DEFAULT = (WAKE_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_STEP = 16'h0002;
	typedef enum logic [1:0] {ACK_IDLE, ACK_MASK, ACK_CLEAR, ACK_CALL} tsic_ack_state_t;
endpackage

// ---- tsic_cpu_model.sv ----
`timescale 1ns/1ps
module tsic_cpu_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] wdata_o,
	output logic last_o,
	output logic halt_o,
	output logic dis_o,
	output logic en_o,
	output logic ret_o,
	output logic carry_o,
	output logic zero_o,
	output logic [15:0] pc_o,
	output logic [17:0] stack_o
);
	initial begin
		{addr_o, rd_o, wr_o, wdata_o, last_o, halt_o, dis_o, en_o, ret_o, carry_o, zero_o} = '0;
		pc_o = 16'h1230;
		stack_o = {2'h2, 16'hBEEF};
	end
	// released bus shows inverted values so a stale latch cannot pass
	task automatic io(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= (a == 8'hFF) ? (v | 8'h01) : v;
		rd_o <= !w;
		wr_o <= w;
		@(posedge clk_i);
		{rd_o, wr_o} <= 2'h0;
		addr_o <= ~a;
		wdata_o <= ~v;
		#1 d = rdata_i;
	endtask
	// k bits: return, enable, disable, halt; one-cycle instructions only
	// flags and stack word follow the pc so every push and pop differs
	task automatic instr(input logic [3:0] k);
		@(posedge clk_i);
		last_o <= 1'b1;
		{ret_o, en_o, dis_o, halt_o} <= k;
		{carry_o, zero_o} <= {pc_o[0], pc_o[1]};
		stack_o <= {pc_o[1:0], pc_o ^ 16'hBEEF};
		@(posedge clk_i);
		last_o <= 1'b0;
		{ret_o, en_o, dis_o, halt_o} <= 4'h0;
		pc_o <= pc_o + 16'h1;
		#1;
	endtask
endmodule // tsic_cpu_model

// ---- test_tsic.sv ----
`timescale 1ns/1ps
module test_tsic;
	import tsic_pkg::*;
	logic clk_sys_i = 0;
	logic reset_i, por_cause_i, wdt_cause_i, usb_dp_i, usb_dm_i, bus_activity_i;
	logic [2:0] ep_packet_done_i;
	logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, rd_v;
	logic io_rd_i, io_wr_i, instr_last_i, cpu_run_o, ack_busy_o, irq_call_o, restore_valid_o;
	logic restore_carry_flag_o, restore_zero_flag_o;
	logic halt_op, dis_op, en_op, ret_op, carry_flag, zero_flag;
	logic [15:0] pc_i, irq_vector_o, restore_pc_o, t0;
	logic [17:0] stack_top_i, stack_push_data_o;
	logic [11:0] timer_count_o, tv;
	int miscompares = 0, checks_done = 0, cyc = 0;
	always #50 clk_sys_i = ~clk_sys_i;
	// short long-wake count keeps the run small
	tsic_top #(.WAKE_LONG_CYCLES(200)) dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
		.por_cause_i(por_cause_i), .wdt_cause_i(wdt_cause_i), .io_addr_i(io_addr_i),
		.io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
		.instr_last_i(instr_last_i), .halt_instr_i(halt_op), .irq_disable_instruction_i(dis_op),
		.irq_enable_instruction_i(en_op), .irq_return_instruction_i(ret_op), .pc_i(pc_i),
		.carry_flag_i(carry_flag), .zero_flag_i(zero_flag), .stack_top_i(stack_top_i),
		.usb_dp_i(usb_dp_i), .usb_dm_i(usb_dm_i), .bus_activity_i(bus_activity_i),
		.ep_packet_done_i(ep_packet_done_i), .cpu_run_o(cpu_run_o), .ack_busy_o(ack_busy_o),
		.irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o),
		.stack_push_data_o(stack_push_data_o), .restore_valid_o(restore_valid_o),
		.restore_pc_o(restore_pc_o), .restore_carry_flag_o(restore_carry_flag_o),
		.restore_zero_flag_o(restore_zero_flag_o), .timer_count_o(timer_count_o));
	tsic_cpu_model cpu (.clk_i(clk_sys_i), .rdata_i(io_rdata_o), .addr_o(io_addr_i),
		.rd_o(io_rd_i), .wr_o(io_wr_i), .wdata_o(io_wdata_i), .last_o(instr_last_i),
		.halt_o(halt_op), .dis_o(dis_op), .en_o(en_op), .ret_o(ret_op),
		.carry_o(carry_flag), .zero_o(zero_flag), .pc_o(pc_i), .stack_o(stack_top_i));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		cpu.io(1'b1, a, v, rd_v);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		cpu.io(1'b0, a, 8'h00, rd_v);
		chk(n, rd_v, e);
	endtask
	task automatic cyc_wait(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic rst(input logic p, input logic w);
		@(posedge clk_sys_i);
		{reset_i, por_cause_i, wdt_cause_i} <= {1'b1, p, w};
		repeat (20) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		cyc_wait(1);
	endtask
	// bounded wait for the call pulse, then vector and pushed state
	task automatic take(input logic [15:0] v);
		int i;
		for (i = 0; i < 20 && irq_call_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
		chk("call", irq_call_o, 1'b1);
		chk("vector", irq_vector_o, v);
		chk("push", stack_push_data_o, {t0[0], t0[1], t0});
	endtask
	// drives both data lines for n cycles, then back to the idle level
	task automatic line(input logic p, input logic m, input int n);
		@(posedge clk_sys_i) {usb_dp_i, usb_dm_i} <= {p, m};
		repeat (n) @(posedge clk_sys_i);
		{usb_dp_i, usb_dm_i} <= 2'h1;
	endtask
	task automatic wake(input int n);
		@(posedge clk_sys_i) bus_activity_i <= 1'b1;
		@(posedge clk_sys_i) bus_activity_i <= 1'b0;
		cyc_wait(n);
	endtask
	initial begin
		{reset_i, por_cause_i, wdt_cause_i, bus_activity_i} <= 4'hC;
		{usb_dp_i, usb_dm_i} <= 2'h1;
		ep_packet_done_i <= 3'h0;
		rst(1'b1, 1'b0);
		chk("run", cpu_run_o, 1'b1);
		rd(ADDR_STATUS, STATUS_POR_VALUE, "status");
		rd(ADDR_GLOBAL_EN, 8'h00, "global en");
		rd(ADDR_EP_EN, 8'h00, "ep en");
		rd(8'h30, 8'h00, "unmapped");
		wr(ADDR_STATUS, 8'h94);
		rd(ADDR_STATUS, 8'h11, "status ro bits");
		$display("test reset done");
		@(timer_count_o);
		#1 tv = timer_count_o;
		rd(ADDR_TMR_LOW, tv[7:0], "timer low");
		cyc_wait(2600);
		rd(ADDR_TMR_HIGH, {4'h0, tv[11:8]}, "timer high");
		tv = timer_count_o;
		cyc_wait(100);
		chk("timer rate", timer_count_o, tv + 12'd10);
		$display("test timer done");
		wr(ADDR_GLOBAL_EN, 8'h02);
		cpu.instr(4'h4);
		for (int i = 0; i < 1400 && timer_count_o[6:0] != 7'h7F; i++) @(posedge clk_sys_i);
		cyc_wait(12);
		rd(ADDR_STATUS, 8'h95, "pending");
		chk("no sample", ack_busy_o, 1'b0);
		t0 = pc_i;
		cpu.instr(4'h0);
		take(16'h0004);
		rd(ADDR_STATUS, 8'h11, "acked");
		wr(ADDR_GLOBAL_EN, 8'h04);
		cpu.instr(4'h4);
		for (int i = 0; i < 11000 && timer_count_o[9:0] != 10'h3FF; i++) @(posedge clk_sys_i);
		cyc_wait(12);
		t0 = pc_i;
		cpu.instr(4'h0);
		take(16'h0006);
		$display("test timer irq done");
		wr(ADDR_GLOBAL_EN, 8'h00);
		wr(ADDR_EP_EN, 8'h05);
		@(posedge clk_sys_i) ep_packet_done_i <= 3'h7;
		@(posedge clk_sys_i) ep_packet_done_i <= 3'h0;
		cpu.instr(4'h4);
		t0 = pc_i;
		cpu.instr(4'h0);
		take(16'h0008);
		cpu.instr(4'h4);
		t0 = pc_i;
		cpu.instr(4'h0);
		take(16'h000C);
		cpu.instr(4'h8);
		cyc_wait(0);
		chk("restore valid", restore_valid_o, 1'b1);
		chk("restore", {restore_carry_flag_o, restore_zero_flag_o, restore_pc_o}, stack_top_i);
		cyc_wait(4);
		rd(ADDR_STATUS, 8'h15, "ep1 gated");
		cpu.instr(4'h2);
		rd(ADDR_STATUS, 8'h11, "disabled");
		$display("test endpoint irq done");
		line(1'b1, 1'b0, 90);
		rd(ADDR_STATUS, 8'h11, "k state");
		line(1'b0, 1'b0, 70);
		rd(ADDR_STATUS, 8'h11, "short se0");
		wr(ADDR_GLOBAL_EN, 8'h03);
		line(1'b0, 1'b0, 90);
		rd(ADDR_STATUS, 8'hB1, "bus reset");
		chk("run kept", cpu_run_o, 1'b1);
		cpu.instr(4'h4);
		t0 = pc_i;
		cpu.instr(4'h0);
		take(16'h0002);
		cpu.instr(4'h1);
		cyc_wait(0);
		chk("halted", cpu_run_o, 1'b0);
		rst(1'b0, 1'b1);
		rd(ADDR_STATUS, STATUS_WDT_VALUE, "wdt status");
		rd(ADDR_EP_EN, 8'h00, "ep cleared");
		wr(ADDR_STATUS, 8'h43);
		cpu.instr(4'h0);
		cyc_wait(0);
		chk("stepped", cpu_run_o, 1'b0);
		$display("test reset causes done");
		rst(1'b0, 1'b1);
		@(posedge clk_sys_i) bus_activity_i <= 1'b1;
		wr(ADDR_STATUS, 8'h49);
		cyc_wait(3);
		chk("suspend refused", cpu_run_o, 1'b1);
		@(posedge clk_sys_i) bus_activity_i <= 1'b0;
		wr(ADDR_STATUS, 8'h49);
		cyc_wait(1);
		chk("asleep", cpu_run_o, 1'b0);
		wake(1200);
		chk("short delay", cpu_run_o, 1'b0);
		cyc_wait(100);
		chk("woken", cpu_run_o, 1'b1);
		rst(1'b1, 1'b0);
		wr(ADDR_STATUS, 8'h19);
		wake(150);
		chk("por early", cpu_run_o, 1'b0);
		cyc_wait(100);
		chk("por wake", cpu_run_o, 1'b1);
		$display("test suspend done");
		stop_test();
	end
endmodule // test_tsic
